// *** src/pin_sync.sv ***
// Two-flop synchroniser for the serial clock, data-in and select pins
`timescale 1ns/1ps
`default_nettype none
`include "spi_port_cfg.svh"

module pin_sync (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  // Pins in, synchronised out
  input  wire logic [2:0] d,
  output logic      [2:0] q
);

  logic [2:0] s1_r;
  logic [2:0] s2_r;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s1_r <= `SYNC_RST;
      s2_r <= `SYNC_RST;
    end else if (ce) begin
      s1_r <= d;
      s2_r <= s1_r;
    end
  end

  assign q = s2_r;

endmodule
`default_nettype wire

// *** src/spi_port.sv ***
// Serial port: slave and master shifting, flags, status and register access
`timescale 1ns/1ps
`default_nettype none
`include "spi_port_cfg.svh"

module spi_port
  import spi_port_pkg::*;
(
  // Clock, reset, enable
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  // Register port
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata,
  // Flag request
  output logic            irq_req,
  // Serial clock pin
  input  wire logic       sck_i,
  output logic            sck_o,
  output logic            sck_oe,
  // Master-out pin
  input  wire logic       mosi_i,
  output logic            mosi_o,
  output logic            mosi_oe,
  // Master-in pin
  input  wire logic       miso_i,
  output logic            miso_o,
  output logic            miso_oe,
  // Select pin
  input  wire logic       nss_i,
  output logic            nss_o,
  output logic            nss_oe
);

  // Rising-edge sampling when phase equals polarity
  function automatic logic samples_on_rise(input logic pha, input logic pol);
    samples_on_rise = (pha == pol);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  localparam logic [7:0] CTRL_RST_V = `CTRL_RST;
  localparam logic [7:0] CFG_RST_V  = `CFG_RST;

  logic [2:0]   sync_q;
  logic         sck_s;
  logic         mosi_s;
  logic         nss_s;
  logic         sck_d_r;
  logic         nss_d_r;
  logic         nss_filt_r;
  logic         port_en_r;
  logic         master_r;
  logic         pha_r;
  logic         pol_r;
  select_mode_t smd_r;
  logic [7:0]   div_r;
  logic         done_f_r;
  logic         write_collision_flag_r;
  logic         mode_fault_flag_r;
  logic         ovr_r;
  logic [7:0]   sr_r;
  logic [2:0]   cnt_r;
  logic         out_bit_r;
  logic         shift_reg_empty_r;
  logic         tx_full_r;
  logic [7:0]   tx_r;
  mst_state_t   mst_st_r;
  logic [7:0]   div_cnt_r;
  logic [4:0]   half_r;
  logic         sck_lvl_r;
  logic         pend_r;
  logic [7:0]   rdata_r;
  logic         wr_ctrl;
  logic         wr_cfg;
  logic         wr_ckr;
  logic         wr_data;
  logic         rd_data;
  logic         sck_rise;
  logic         sck_fall;
  logic         nss_fall;
  logic         slave_sel;
  logic         smp_edge;
  logic         sft_edge;
  logic         slv_done;
  logic         mst_term;
  logic         mst_last;
  logic         mst_done;
  logic         mst_start;
  logic         slv_load;
  logic         tx_take;
  logic         byte_done;
  logic [7:0]   byte_val;
  logic         mode_fault_flag_ev;
  logic         rx_in_ready;
  logic         rx_out_valid;
  logic [7:0]   rx_out_data;
  logic         busy;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation and edge detection

  pin_sync u_sync (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .ce      (ce),
    .d       ({sck_i, mosi_i, nss_i}),
    .q       (sync_q)
  );

  assign sck_s  = sync_q[2];
  assign mosi_s = sync_q[1];
  assign nss_s  = sync_q[0];

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sck_d_r    <= 1'b0;
      nss_d_r    <= 1'b1;
      nss_filt_r <= 1'b1;
    end else if (ce) begin
      sck_d_r <= sck_s;
      nss_d_r <= nss_s;
      // Two agreeing samples filter single-cycle glitches
      if (nss_s == nss_d_r) begin
        nss_filt_r <= nss_s;
      end
    end
  end

  assign sck_rise = sck_s & ~sck_d_r;
  assign sck_fall = ~sck_s & sck_d_r;
  assign nss_fall = ~nss_s & nss_d_r;

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode and byte events

  assign slave_sel = port_en_r & ~master_r &
                     ((smd_r == SM_3WIRE) | ((smd_r == SM_4SLAVE) & ~nss_s));
  assign smp_edge  = slave_sel & (samples_on_rise(pha_r, pol_r) ? sck_rise : sck_fall);
  assign sft_edge  = slave_sel & (samples_on_rise(pha_r, pol_r) ? sck_fall : sck_rise);
  assign slv_done  = smp_edge & (cnt_r == `BIT_LAST);

  assign mst_term  = (mst_st_r == M_RUN) & (div_cnt_r == div_r);
  assign mst_last  = (half_r == (pha_r ? `HALF_LAST_PHA1 : `HALF_LAST_PHA0));
  assign mst_done  = mst_term & mst_last;
  assign mst_start = port_en_r & master_r & (mst_st_r == M_IDLE) & tx_full_r &
                     rx_in_ready;
  assign slv_load  = port_en_r & ~master_r & tx_full_r &
                     ((shift_reg_empty_r & (cnt_r == 3'h0) & ~smp_edge) | slv_done);
  assign tx_take   = mst_start | slv_load;

  assign byte_done = slv_done | mst_done;
  assign byte_val  = {sr_r[6:0], (slv_done ? mosi_s : miso_i)};
  assign mode_fault_flag_ev   = port_en_r & master_r & (smd_r == SM_4SLAVE) & ~nss_s;

  ////////////////////////////////////////////////////////////////////////////
  // Register access strobes

  assign wr_ctrl = ce & sfr_wr & (sfr_addr == `CTRL_OFS);
  assign wr_cfg  = ce & sfr_wr & (sfr_addr == `CFG_OFS);
  assign wr_ckr  = ce & sfr_wr & (sfr_addr == `CKR_OFS);
  assign wr_data = ce & sfr_wr & (sfr_addr == `DATA_OFS);
  assign rd_data = ce & sfr_rd & (sfr_addr == `DATA_OFS);

  ////////////////////////////////////////////////////////////////////////////
  // Control and configuration registers

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      port_en_r <= CTRL_RST_V[`CTRL_EN];
      smd_r     <= select_mode_t'(CTRL_RST_V[`CTRL_SMD_HI:`CTRL_SMD_LO]);
      master_r  <= CFG_RST_V[`CFG_MASTER_ENABLE];
      pha_r     <= CFG_RST_V[`CFG_PHA];
      pol_r     <= CFG_RST_V[`CFG_POL];
      div_r     <= `CKR_RST;
    end else if (ce) begin
      if (wr_ctrl) begin
        port_en_r <= sfr_wdata[`CTRL_EN];
        smd_r     <= select_mode_t'(sfr_wdata[`CTRL_SMD_HI:`CTRL_SMD_LO]);
      end
      if (wr_cfg) begin
        master_r <= sfr_wdata[`CFG_MASTER_ENABLE];
        pha_r    <= sfr_wdata[`CFG_PHA];
        pol_r    <= sfr_wdata[`CFG_POL];
      end
      if (wr_ckr) begin
        div_r <= sfr_wdata;
      end
      // Fault overrides a software write in the same cycle
      if (mode_fault_flag_ev) begin
        master_r  <= 1'b0;
        port_en_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky flags: hardware set wins over a software clear

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      done_f_r <= 1'b0;
      write_collision_flag_r   <= 1'b0;
      mode_fault_flag_r   <= 1'b0;
      ovr_r    <= 1'b0;
    end else if (ce) begin
      done_f_r <= byte_done | (wr_ctrl ? sfr_wdata[`CTRL_DONE] : done_f_r);
      write_collision_flag_r   <= (wr_data & tx_full_r & ~tx_take) |
                  (wr_ctrl ? sfr_wdata[`CTRL_WRITE_COLLISION_FLAG] : write_collision_flag_r);
      mode_fault_flag_r   <= mode_fault_flag_ev | (wr_ctrl ? sfr_wdata[`CTRL_MODE_FAULT_FLAG] : mode_fault_flag_r);
      ovr_r    <= (slv_done & ~rx_in_ready) |
                  (wr_ctrl ? sfr_wdata[`CTRL_OVR] : ovr_r);
    end
  end

  assign irq_req = done_f_r | write_collision_flag_r | mode_fault_flag_r | ovr_r;

  ////////////////////////////////////////////////////////////////////////////
  // Transmit buffer

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      tx_full_r <= 1'b0;
      tx_r      <= 8'h00;
    end else if (ce) begin
      if (wr_data && (!tx_full_r || tx_take)) begin
        tx_r      <= sfr_wdata;
        tx_full_r <= 1'b1;
      end else if (tx_take) begin
        tx_full_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shift path: slave counter, shifter shared with the master, and slave outgoing bit

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cnt_r <= 3'h0;
    end else if (ce) begin
      if (!port_en_r) begin
        cnt_r <= 3'h0;
      end else if ((smd_r == SM_4SLAVE) && nss_fall) begin
        cnt_r <= 3'h0;
      end else if (smp_edge) begin
        cnt_r <= cnt_r + 3'h1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sr_r      <= 8'h00;
      out_bit_r <= 1'b0;
    end else if (ce) begin
      if (tx_take) begin
        sr_r      <= tx_r;
        out_bit_r <= tx_r[7];
      end else if (mst_term && pend_r) begin
        // Capture in the cycle of the next shifting edge, div_r+1 clocks after sampling, for slave settling
        sr_r <= {sr_r[6:0], miso_i};
      end else if (smp_edge) begin
        sr_r <= {sr_r[6:0], mosi_s};
      end else if (sft_edge) begin
        out_bit_r <= sr_r[7];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      shift_reg_empty_r <= 1'b1;
    end else if (ce) begin
      if (slv_done && !tx_full_r) begin
        shift_reg_empty_r <= 1'b1;
        // A phase-0 trailing shift edge closes a byte, it starts none
      end else if (slv_load || smp_edge || (sft_edge && pha_r)) begin
        shift_reg_empty_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Master sequencer: divider, half-period count, sample tracking

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      mst_st_r  <= M_IDLE;
      div_cnt_r <= 8'h00;
      half_r    <= 5'h00;
      sck_lvl_r <= 1'b0;
      pend_r    <= 1'b0;
    end else if (ce) begin
      unique case (mst_st_r)
        M_IDLE: begin
          div_cnt_r <= 8'h00;
          half_r    <= 5'h00;
          sck_lvl_r <= 1'b0;
          pend_r    <= 1'b0;
          if (mst_start) begin
            mst_st_r <= M_RUN;
          end
        end
        M_RUN: begin
          if (mode_fault_flag_ev) begin
            mst_st_r <= M_IDLE;
          end else if (mst_term) begin
            div_cnt_r <= 8'h00;
            half_r    <= half_r + 5'h01;
            if (half_r < `HALF_EDGES) begin
              sck_lvl_r <= ~sck_lvl_r;
            end
            // Sampling edges are the odd ones for phase 0, even ones for phase 1
            pend_r <= (half_r < `HALF_EDGES) & (half_r[0] == pha_r);
            if (mst_last) begin
              mst_st_r <= M_IDLE;
            end
          end else begin
            div_cnt_r <= div_cnt_r + 8'h01;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive buffer; the master waits for room, the slave reports overrun

  two_entry_buf u_rx_buf (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .ce        (ce),
    .in_valid  (byte_done),
    .in_ready  (rx_in_ready),
    .in_data   (byte_val),
    .out_valid (rx_out_valid),
    .out_ready (rd_data),
    .out_data  (rx_out_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read-back

  assign busy = (mst_st_r == M_RUN) | (slave_sel & (cnt_r != 3'h0));

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rdata_r <= 8'h00;
    end else if (ce && sfr_rd) begin
      unique case (sfr_addr)
        `CFG_OFS: begin
          rdata_r <= {busy, master_r, pha_r, pol_r,
                      ~nss_filt_r,
                      nss_i,
                      master_r | shift_reg_empty_r,
                      master_r | ~rx_out_valid};
        end
        `CTRL_OFS: begin
          rdata_r <= {done_f_r, write_collision_flag_r, mode_fault_flag_r, ovr_r, smd_r,
                      ~tx_full_r, port_en_r};
        end
        `DATA_OFS: begin
          rdata_r <= rx_out_data;
        end
        `CKR_OFS: begin
          rdata_r <= div_r;
        end
        default: begin
          rdata_r <= 8'h00;
        end
      endcase
    end
  end

  assign sfr_rdata = rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers

  assign sck_o   = pol_r ^ sck_lvl_r;
  assign sck_oe  = port_en_r & master_r;
  assign mosi_o  = sr_r[7];
  assign mosi_oe = port_en_r & master_r;
  assign miso_o  = out_bit_r;
  assign miso_oe = slave_sel;
  assign nss_o   = smd_r[0];
  assign nss_oe  = port_en_r & master_r & smd_r[1];

endmodule
`default_nettype wire

// *** src/spi_port_cfg.svh ***
// Register offsets, field positions, reset values and counts of the serial port
`ifndef SPI_PORT_CFG_SVH
`define SPI_PORT_CFG_SVH

// Register offsets
`define CFG_OFS        8'h9A
`define DATA_OFS       8'h9B
`define CKR_OFS        8'h9D
`define CTRL_OFS       8'hF8

// Reset values
`define CFG_RST        8'h07
`define CTRL_RST       8'h06
`define CKR_RST        8'h00
`define SYNC_RST       3'h1

// Configuration/status fields
`define CFG_BUSY       7
`define CFG_MASTER_ENABLE      6
`define CFG_PHA        5
`define CFG_POL        4
`define CFG_SEL        3
`define CFG_RAW        2
`define CFG_SHIFT_REG_EMPTY       1
`define CFG_RX_BUFFER_EMPTY      0

// Control fields
`define CTRL_DONE      7
`define CTRL_WRITE_COLLISION_FLAG      6
`define CTRL_MODE_FAULT_FLAG      5
`define CTRL_OVR       4
`define CTRL_SMD_HI    3
`define CTRL_SMD_LO    2
`define CTRL_TX_BUFFER_EMPTY     1
`define CTRL_EN        0

// Counts
`define BIT_LAST       3'h7
`define HALF_LAST_PHA0 5'h0F
`define HALF_LAST_PHA1 5'h10
`define HALF_EDGES     5'h10
`define BUF_DEPTH      2'h2

`endif

// *** src/spi_port_pkg.sv ***
// Types shared by the serial port design
package spi_port_pkg;

  typedef enum logic [1:0] {
    SM_3WIRE  = 2'b00,
    SM_4SLAVE = 2'b01,
    SM_MST_LO = 2'b10,
    SM_MST_HI = 2'b11
  } select_mode_t;

  typedef enum logic {
    M_IDLE = 1'b0,
    M_RUN  = 1'b1
  } mst_state_t;

endpackage

// *** src/two_entry_buf.sv ***
// Two-entry byte buffer with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
`include "spi_port_cfg.svh"

module two_entry_buf (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  // Fill side
  input  wire logic       in_valid,
  output logic            in_ready,
  input  wire logic [7:0] in_data,
  // Drain side
  output logic            out_valid,
  input  wire logic       out_ready,
  output logic      [7:0] out_data
);

  logic [7:0] mem_r [0:1];
  logic       wr_ptr_r;
  logic       rd_ptr_r;
  logic [1:0] cnt_r;
  logic       push;
  logic       pop;

  assign in_ready  = (cnt_r != `BUF_DEPTH);
  assign out_valid = (cnt_r != 2'h0);
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem_r[rd_ptr_r];

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      mem_r[0] <= 8'h00;
      mem_r[1] <= 8'h00;
      wr_ptr_r <= 1'b0;
    end else if (ce && push) begin
      mem_r[wr_ptr_r] <= in_data;
      wr_ptr_r        <= ~wr_ptr_r;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rd_ptr_r <= 1'b0;
      cnt_r    <= 2'h0;
    end else if (ce) begin
      if (pop) begin
        rd_ptr_r <= ~rd_ptr_r;
      end
      if (push && !pop) begin
        cnt_r <= cnt_r + 2'h1;
      end else if (pop && !push) begin
        cnt_r <= cnt_r - 2'h1;
      end
    end
  end

endmodule
`default_nettype wire

// *** verif/spi_master_model.sv ***
// Behavioural external master that clocks the serial port as a slave
`timescale 1ns/1ps
`default_nettype none

module spi_master_model (
  // Clock
  input  wire logic ref_clk,
  // Link pins
  output logic      sck,
  output logic      mosi,
  output logic      nss,
  input  wire logic miso
);
  initial begin
    sck  = 1'b0;
    mosi = 1'b0;
    nss  = 1'b1;
  end

  task automatic drive_sel(input logic v);
    @(negedge ref_clk);
    nss = v;
  endtask

  // Half period of six clocks keeps the bit rate at one twelfth
  task automatic xfer(input logic [7:0] tx, input int nb, input logic sel,
                      input logic pol, input logic pha, output logic [7:0] rx);
    logic [7:0] sh;
    sh = tx;
    rx = 8'h00;
    @(negedge ref_clk);
    sck = pol;
    repeat (2) @(negedge ref_clk);
    nss = ~sel;
    if (!pha) begin
      mosi = sh[7];
      sh   = sh << 1;
    end
    repeat (4) @(negedge ref_clk);
    for (int i = 0; i < nb; i++) begin
      if (pha) begin
        sck  = ~sck;
        mosi = sh[7];
        sh   = sh << 1;
      end
      repeat (6) @(negedge ref_clk);
      sck = ~sck;
      rx  = {rx[6:0], miso};
      repeat (6) @(negedge ref_clk);
      if (!pha) begin
        sck  = ~sck;
        mosi = sh[7];
        sh   = sh << 1;
      end
    end
    repeat (4) @(negedge ref_clk);
    nss  = 1'b1;
    // Released line must not keep looking like the last bit
    mosi = ~mosi;
    repeat (6) @(negedge ref_clk);
  endtask
endmodule

`default_nettype wire

// *** verif/spi_port_checker.sv ***
// Concurrent checks on the serial port's register and pin outputs
`timescale 1ns/1ps
`default_nettype none
`include "spi_port_cfg.svh"

module spi_port_checker
  import spi_port_pkg::*;
(
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  // Register port
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic [7:0] sfr_rdata,
  input  wire logic       irq_req,
  // Pins
  input  wire logic       sck_oe,
  input  wire logic       mosi_oe,
  input  wire logic       miso_oe,
  input  wire logic       nss_i,
  input  wire logic       nss_o,
  input  wire logic       nss_oe
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  logic mapped;
  assign mapped = sfr_addr == `CFG_OFS || sfr_addr == `DATA_OFS ||
                  sfr_addr == `CKR_OFS || sfr_addr == `CTRL_OFS;

  sequence rd_at(logic [7:0] a);
    sfr_rd && ce && sfr_addr == a;
  endsequence

  a_rdata_holds: assert property (!(sfr_rd && ce) |=> $stable(sfr_rdata))
    else $error("read data moved without a read");
  a_unmapped_zero: assert property (sfr_rd && ce && !mapped |=> sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_irq_flags: assert property (rd_at(`CTRL_OFS) |=> (|sfr_rdata[7:4]) == $past(irq_req))
    else $error("request differs from flags");
  a_irq_sticky: assert property (
    irq_req && !(sfr_wr && ce && sfr_addr == `CTRL_OFS) |=> irq_req)
    else $error("flag dropped without a write");
  a_raw_pin: assert property (rd_at(`CFG_OFS) |=> sfr_rdata[`CFG_RAW] == $past(nss_i))
    else $error("raw select bit wrong");
  a_master_status: assert property (
    rd_at(`CFG_OFS) ##0 sck_oe |=> sfr_rdata[1:0] == 2'b11 && sfr_rdata[`CFG_MASTER_ENABLE])
    else $error("master status bits wrong");
  a_slave_status: assert property (rd_at(`CFG_OFS) ##0 miso_oe |=> !sfr_rdata[`CFG_MASTER_ENABLE])
    else $error("slave drives while master");
  a_pin_roles: assert property (miso_oe |-> !mosi_oe && !sck_oe)
    else $error("slave and master pins both driven");
  a_select_drive: assert property (
    rd_at(`CTRL_OFS) ##0 nss_oe |=> sfr_rdata[3:2] == {1'b1, $past(nss_o)} && sfr_rdata[0])
    else $error("select output not from mode bit");
endmodule

bind spi_port spi_port_checker u_checker (
  .ref_clk, .rst_n, .ce, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_rdata, .irq_req,
  .sck_oe, .mosi_oe, .miso_oe, .nss_i, .nss_o, .nss_oe
);

`default_nettype wire

// *** verif/tb_spi_port.sv ***
// Self-checking bench: registers, slave frames, master loopback, faults
`timescale 1ns/1ps
`default_nettype none
`include "spi_port_cfg.svh"

module tb_spi_port
  import spi_port_pkg::*;
();
  logic       ref_clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       ce = 1'b1;
  logic       sfr_wr = 1'b0;
  logic       sfr_rd = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] sfr_rdata, got, rx, sb;
  logic       irq_req, sck_i, sck_o, sck_oe, mosi_i, mosi_o, mosi_oe;
  logic       miso_i, miso_o, miso_oe, nss_i, nss_o, nss_oe;
  logic       pm_sck, pm_mosi, pm_nss, miso_line;
  int         n_fail = 0;
  int         num_checks = 0;
  int         n_sck = 0;

  always #12.5 ref_clk = ~ref_clk;

  // Rising serial clock edges driven by the port as master
  always @(posedge sck_o) n_sck++;

  // Wire levels from all enables; master input strapped to its own output
  assign sck_i     = sck_oe ? sck_o : pm_sck;
  assign mosi_i    = mosi_oe ? mosi_o : pm_mosi;
  assign nss_i     = nss_oe ? nss_o : pm_nss;
  assign miso_line = miso_oe ? miso_o : 1'b1;
  assign miso_i    = miso_oe ? miso_o : mosi_i;

  spi_port dut (
    .ref_clk, .rst_n, .ce, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata,
    .irq_req, .sck_i, .sck_o, .sck_oe, .mosi_i, .mosi_o, .mosi_oe, .miso_i, .miso_o,
    .miso_oe, .nss_i, .nss_o, .nss_oe
  );

  spi_master_model pm (.ref_clk, .sck(pm_sck), .mosi(pm_mosi), .nss(pm_nss), .miso(miso_line));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    sfr_addr  = a;
    sfr_wdata = d;
    sfr_wr    = 1'b1;
    @(negedge ref_clk);
    sfr_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(negedge ref_clk);
    sfr_addr = a;
    sfr_rd   = 1'b1;
    @(negedge ref_clk);
    sfr_rd = 1'b0;
    got    = sfr_rdata;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    rd(a);
    chk(got & m, e);
  endtask

  task automatic tend(input string s);
    $display("test %s finished", s);
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    $display("[ERR] %0t watchdog expired", $time);
    end_sim();
  end

  initial begin
    repeat (6) @(negedge ref_clk);
    rst_n = 1'b1;
    rdc(`CFG_OFS, 8'h07, 8'hFF);
    rdc(`CTRL_OFS, 8'h06, 8'hFF);
    rdc(`CKR_OFS, 8'h00, 8'hFF);
    // A write with the clock enable low must not land
    ce = 1'b0;
    wr(`CKR_OFS, 8'h5A);
    ce = 1'b1;
    rdc(`CKR_OFS, 8'h00, 8'hFF);
    wr(8'h55, 8'hFF);
    rdc(8'h55, 8'h00, 8'hFF);
    tend("reset");
    // Four-wire slave in all four phase and polarity settings
    for (int k = 0; k < 4; k++) begin
      sb = 8'hC5 ^ {4{k[1:0]}};
      wr(`CTRL_OFS, 8'h04);
      wr(`CFG_OFS, {2'b00, k[1:0], 4'h0});
      wr(`CTRL_OFS, 8'h05);
      wr(`DATA_OFS, sb);
      rdc(`CTRL_OFS, 8'h07, 8'hFF);
      rdc(`CFG_OFS, {2'b00, k[1:0], 4'h5}, 8'h7F);
      pm.xfer(~sb, 8, 1'b1, k[0], k[1], rx);
      chk(rx, sb);
      rdc(`CTRL_OFS, 8'h87, 8'hFF);
      chk({7'h00, irq_req}, 8'h01);
      rdc(`DATA_OFS, ~sb, 8'hFF);
      rdc(`CFG_OFS, 8'h07, 8'h8F);
      wr(`CTRL_OFS, 8'h05);
      @(negedge ref_clk);
      chk({7'h00, irq_req}, 8'h00);
    end
    tend("slave modes");
    // Three-wire slave: queued byte, collision, overrun
    wr(`CTRL_OFS, 8'h00);
    wr(`CFG_OFS, 8'h30);
    wr(`CTRL_OFS, 8'h01);
    wr(`DATA_OFS, 8'h11);
    wr(`DATA_OFS, 8'h22);
    wr(`DATA_OFS, 8'h33);
    rdc(`CTRL_OFS, 8'h41, 8'hFF);
    chk({7'h00, miso_oe}, 8'h01);
    pm.xfer(8'hB1, 8, 1'b0, 1'b1, 1'b1, rx);
    chk(rx, 8'h11);
    pm.xfer(8'hB2, 8, 1'b0, 1'b1, 1'b1, rx);
    chk(rx, 8'h22);
    pm.xfer(8'hB3, 8, 1'b0, 1'b1, 1'b1, rx);
    rdc(`CTRL_OFS, 8'hD0, 8'hF0);
    rdc(`DATA_OFS, 8'hB1, 8'hFF);
    rdc(`DATA_OFS, 8'hB2, 8'hFF);
    rdc(`CFG_OFS, 8'h01, 8'h01);
    wr(`CTRL_OFS, 8'h00);
    @(negedge ref_clk);
    chk({7'h00, miso_oe}, 8'h00);
    tend("three wire");
    // Aborted frame is realigned by the next select
    wr(`CFG_OFS, 8'h00);
    wr(`CTRL_OFS, 8'h05);
    pm.xfer(8'hFF, 3, 1'b1, 1'b0, 1'b0, rx);
    pm.xfer(8'h69, 8, 1'b1, 1'b0, 1'b0, rx);
    rdc(`DATA_OFS, 8'h69, 8'hFF);
    rdc(`CFG_OFS, 8'h01, 8'h01);
    tend("realign");
    // Master loopback with select driven high
    wr(`CKR_OFS, 8'h01);
    wr(`CTRL_OFS, 8'h0C);
    wr(`CFG_OFS, 8'h40);
    wr(`CTRL_OFS, 8'h09);
    @(negedge ref_clk);
    chk({6'h00, nss_oe, nss_o}, 8'h02);
    wr(`CTRL_OFS, 8'h0D);
    @(negedge ref_clk);
    chk({6'h00, nss_oe, nss_o}, 8'h03);
    n_sck = 0;
    wr(`DATA_OFS, 8'hA7);
    rdc(`CFG_OFS, 8'hC0, 8'hC0);
    got = 8'h00;
    for (int k = 0; k < 60 && got[7] !== 1'b1; k++) begin
      rd(`CTRL_OFS);
    end
    chk(got & 8'h80, 8'h80);
    rdc(`DATA_OFS, 8'hA7, 8'hFF);
    chk(n_sck[7:0], 8'h08);
    rdc(`CFG_OFS, 8'h43, 8'hC3);
    tend("master");
    // Another master pulls select low
    wr(`CTRL_OFS, 8'h05);
    pm.drive_sel(1'b0);
    repeat (8) @(negedge ref_clk);
    rdc(`CTRL_OFS, 8'h26, 8'hFF);
    rdc(`CFG_OFS, 8'h00, 8'h40);
    pm.drive_sel(1'b1);
    tend("mode fault");
    end_sim();
  end
endmodule

`default_nettype wire
